// File: rtl/cbs_pkg.sv
// Shared types and constants for the CAN bit synchronizer
package cbs_pkg;

   // ==========================================================
   // Widths
   localparam int BRP_W = 6;
   localparam int TS1_W = 5;
   localparam int PS2_W = 4;
   localparam int SJW_W = 2;
   localparam int CNT_W = 6;

   // ==========================================================
   // Reset values
   localparam logic [BRP_W-1:0] PRE_CNT_RST = 6'h00;
   localparam logic [CNT_W-1:0] SEG_CNT_RST = 6'h00;
   localparam logic             RECESSIVE   = 1'b1;
   localparam logic             DOMINANT    = 1'b0;

   // ==========================================================
   // Bit-time segment, one-hot
   typedef enum logic [2:0]
   {
      CBS_SYNC = 3'b001,
      CBS_TS1  = 3'b010,
      CBS_PS2  = 3'b100
   } cbs_seg_e;

   // Bit timing settings: segment lengths in time quanta, jump length less one in quanta, prescaler length less one in clocks
   typedef struct packed
   {
      logic [BRP_W-1:0] brp_m1;
      logic [TS1_W-1:0] tseg1;
      logic [PS2_W-1:0] ps2;
      logic [SJW_W-1:0] sjw_m1;
   } cbs_cfg_s;

endpackage : cbs_pkg

// File: rtl/cbs_bit_sync.sv
// CAN bit-timing synchronizer: hard sync and resync with jump width
// ==========================================================
`timescale 1ns/1ns
`default_nettype none

module cbs_bit_sync
(
   input  wire logic          i_clk_sys,
   input  wire logic          i_sys_rst,
   input  wire logic          i_clk_en,
   input  wire logic          i_rx,
   input  wire logic          i_bus_idle,
   input  wire logic          i_tx_dominant,
   input  wire cbs_pkg::cbs_cfg_s i_cfg,
   output var cbs_pkg::cbs_seg_e o_segment,
   output logic               o_tq_tick,
   output logic               o_sample,
   output logic               o_rx_bit,
   output logic               o_hard_sync,
   output logic               o_resync
);

   // ==========================================================
   // Helpers
   function automatic logic [cbs_pkg::CNT_W-1:0] sjw_len(input logic [cbs_pkg::SJW_W-1:0] m1);
      sjw_len = cbs_pkg::CNT_W'({1'b0, m1}) + 6'h01;
   endfunction : sjw_len

   // ==========================================================
   // Pin synchronizer
   logic rx_meta_r;
   logic rx_s_r;
   logic rx_q_r;

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rx_meta_r <= cbs_pkg::RECESSIVE;
         rx_s_r    <= cbs_pkg::RECESSIVE;
      end
      else if (i_clk_en)
      begin
         rx_meta_r <= i_rx;
         rx_s_r    <= rx_meta_r;
      end
   end

   // ==========================================================
   // Quantum prescaler
   logic [cbs_pkg::BRP_W-1:0] pre_cnt_r;
   logic                      tick;

   assign tick = i_clk_en && (pre_cnt_r == i_cfg.brp_m1);

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         pre_cnt_r <= cbs_pkg::PRE_CNT_RST;
      else if (tick)
         pre_cnt_r <= cbs_pkg::PRE_CNT_RST;
      else if (i_clk_en)
         pre_cnt_r <= pre_cnt_r + 6'h01;
   end

   // ==========================================================
   // Edge qualification and phase error
   cbs_pkg::cbs_seg_e         seg_r;
   logic [cbs_pkg::CNT_W-1:0] cnt_r;
   logic                      sync_done_r;
   logic                      ext_r;
   logic                      shr_r;
   logic [cbs_pkg::CNT_W-1:0] resync_jump_width;
   logic [cbs_pkg::CNT_W-1:0] ps2_len;
   logic [cbs_pkg::CNT_W-1:0] err_mag;
   logic                      edge_ok;
   logic                      hs;
   logic                      rs;
   logic                      small_err;
   logic                      ext_now;
   logic                      shr_now;
   logic [cbs_pkg::CNT_W-1:0] end1;
   logic [cbs_pkg::CNT_W-1:0] end2;

   assign resync_jump_width     = sjw_len(i_cfg.sjw_m1);
   assign ps2_len = cbs_pkg::CNT_W'(i_cfg.ps2);
   // Level seen at the previous quantum against now; only a fall counts
   assign edge_ok = tick && rx_q_r && (rx_s_r == cbs_pkg::DOMINANT)
                    && (o_rx_bit == cbs_pkg::RECESSIVE);
   assign hs      = edge_ok && i_bus_idle && !sync_done_r;
   // Positive error while sending dominant would follow our own edge
   assign rs      = edge_ok && !i_bus_idle && !sync_done_r && (seg_r != cbs_pkg::CBS_SYNC)
                    && !(i_tx_dominant && (seg_r == cbs_pkg::CBS_TS1));

   always_comb
   begin
      unique case (seg_r)
         cbs_pkg::CBS_TS1: err_mag = cnt_r + 6'h01;
         cbs_pkg::CBS_PS2: err_mag = ps2_len - cnt_r;
         default:          err_mag = 6'h00;
      endcase
   end

   assign small_err = (err_mag <= resync_jump_width);
   assign ext_now   = ext_r || (rs && !small_err && (seg_r == cbs_pkg::CBS_TS1));
   assign shr_now   = shr_r || (rs && !small_err && (seg_r == cbs_pkg::CBS_PS2));
   assign end1      = cbs_pkg::CNT_W'(i_cfg.tseg1) + (ext_now ? resync_jump_width : 6'h00) - 6'h01;
   assign end2      = ps2_len - (shr_now ? resync_jump_width : 6'h00) - 6'h01;

   // ==========================================================
   // Bit-time sequencer
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         seg_r       <= cbs_pkg::CBS_SYNC;
         cnt_r       <= cbs_pkg::SEG_CNT_RST;
         sync_done_r <= 1'b0;
         ext_r       <= 1'b0;
         shr_r       <= 1'b0;
      end
      else if (tick)
      begin
         ext_r <= ext_now;
         shr_r <= shr_now;
         if (hs || (rs && small_err))
         begin
            // Quantum that held the edge becomes the sync segment
            seg_r       <= cbs_pkg::CBS_TS1;
            cnt_r       <= cbs_pkg::SEG_CNT_RST;
            sync_done_r <= 1'b1;
            ext_r       <= 1'b0;
            shr_r       <= 1'b0;
         end
         else
         begin
            if (rs)
               sync_done_r <= 1'b1;
            unique case (seg_r)
               cbs_pkg::CBS_SYNC:
               begin
                  seg_r       <= cbs_pkg::CBS_TS1;
                  cnt_r       <= cbs_pkg::SEG_CNT_RST;
                  sync_done_r <= 1'b0;
                  ext_r       <= 1'b0;
                  shr_r       <= 1'b0;
               end
               cbs_pkg::CBS_TS1:
               begin
                  if (cnt_r >= end1)
                  begin
                     seg_r <= cbs_pkg::CBS_PS2;
                     cnt_r <= cbs_pkg::SEG_CNT_RST;
                  end
                  else
                     cnt_r <= cnt_r + 6'h01;
               end
               default:
               begin
                  if (cnt_r >= end2)
                  begin
                     seg_r <= cbs_pkg::CBS_SYNC;
                     cnt_r <= cbs_pkg::SEG_CNT_RST;
                  end
                  else
                     cnt_r <= cnt_r + 6'h01;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Sampling and registered outputs
   logic sample_now;

   assign sample_now = tick && !(hs || (rs && small_err))
                       && (seg_r == cbs_pkg::CBS_TS1) && (cnt_r >= end1);

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rx_q_r      <= cbs_pkg::RECESSIVE;
         o_rx_bit    <= cbs_pkg::RECESSIVE;
         o_tq_tick   <= 1'b0;
         o_sample    <= 1'b0;
         o_hard_sync <= 1'b0;
         o_resync    <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (tick)
            rx_q_r <= rx_s_r;
         if (sample_now)
            o_rx_bit <= rx_s_r;
         o_tq_tick   <= tick;
         o_sample    <= sample_now;
         o_hard_sync <= hs;
         o_resync    <= rs;
      end
   end

   assign o_segment = seg_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   hard_sync_idle_a: assert property ($rose(o_hard_sync) |-> $past(i_bus_idle))
      else $error("hard sync outside bus idle");
   hard_restart_a: assert property ($rose(o_hard_sync) |-> seg_r == cbs_pkg::CBS_TS1 && cnt_r == 6'h00)
      else $error("hard sync did not restart bit");
   one_sync_bit_a: assert property ($rose(o_resync) |-> !$past(sync_done_r))
      else $error("second sync in one bit");
   // Phase 1 never runs past its length plus the jump width, however many edges arrive
   sjw_range_a: assert property ($rose(seg_r == cbs_pkg::CBS_PS2) |->
                                 $past(cnt_r) <= cbs_pkg::CNT_W'(i_cfg.tseg1) + cbs_pkg::CNT_W'(i_cfg.sjw_m1))
      else $error("phase 1 beyond jump width");
   falling_edge_a: assert property ($rose(o_hard_sync || o_resync) |-> $past(rx_q_r) && !$past(rx_s_r))
      else $error("sync without falling edge");
   qualify_edge_a: assert property ($rose(o_resync) |-> $past(o_rx_bit) == cbs_pkg::RECESSIVE)
      else $error("edge matched last sample");
   lengthen_ps1_a: assert property ($rose(seg_r == cbs_pkg::CBS_PS2) && $past(ext_r)
                                    |-> $past(cnt_r) == cbs_pkg::CNT_W'(i_cfg.tseg1) + resync_jump_width - 6'h01)
      else $error("phase 1 not lengthened by jump width");
   // Shortening may end phase 2 in the very quantum that sets it, so look at the live value
   shorten_ps2_a: assert property ($rose(seg_r == cbs_pkg::CBS_SYNC) && $past(shr_now)
                                   |-> $past(cnt_r) == ps2_len - resync_jump_width - 6'h01)
      else $error("phase 2 not shortened by jump width");
   tx_dom_pos_a: assert property ($rose(o_resync) |-> !($past(i_tx_dominant) && $past(seg_r) == cbs_pkg::CBS_TS1))
      else $error("resync on positive error while sending dominant");
   sample_bit_a: assert property ($rose(o_sample) |-> o_rx_bit == $past(rx_s_r))
      else $error("sampled bit not stored");

   hard_sync_c: cover property ($rose(o_hard_sync));
   resync_c: cover property ($rose(o_resync));
   lengthen_c: cover property ($rose(ext_r));
   shorten_c: cover property ($rose(shr_r));

endmodule : cbs_bit_sync

`default_nettype wire

// File: verif/cbs_bus_node.sv
// Bus model: the other nodes and this node share one open-drain line
`timescale 1ns/1ns
`default_nettype none

module cbs_bus_node
(
   input  wire logic i_others_dom,
   input  wire logic i_self_dom,
   output logic      o_rx
);
   // ==========================================================
   // Wired-AND
   // Any dominant driver wins; recessive needs every driver released
   assign o_rx = (i_others_dom | i_self_dom) ? cbs_pkg::DOMINANT : cbs_pkg::RECESSIVE;
endmodule : cbs_bus_node

`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the bit synchronizer
`timescale 1ns/1ns
`default_nettype none

module tb;
   // ==========================================================
   // Signals and helpers
   logic              clk;
   logic              rst;
   logic              en;
   logic              idle;
   logic              tx_dom;
   logic              oth_dom;
   logic              rx;
   cbs_pkg::cbs_cfg_s cfg;
   cbs_pkg::cbs_seg_e seg;
   logic              tick, smp, rx_bit, hs, rs;
   int                cyc = 0;
   int                bad_count = 0;
   int                compares = 0;
   int                h, r, k;
   logic [15:0]       notes[$];

   cbs_bus_node bus (.i_others_dom(oth_dom), .i_self_dom(tx_dom), .o_rx(rx));
   cbs_bit_sync dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(en), .i_rx(rx), .i_bus_idle(idle),
      .i_tx_dominant(tx_dom), .i_cfg(cfg), .o_segment(seg), .o_tq_tick(tick), .o_sample(smp),
      .o_rx_bit(rx_bit), .o_hard_sync(hs), .o_resync(rs));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
      cyc <= cyc + 1;

   task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic summarize();
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize

   // Inputs move 1 ns after edge n, clear of the sampling edge
   task automatic go(input int n);
      while (cyc < n)
      begin
         @(posedge clk);
         #1;
      end
   endtask : go

   task automatic at(input int n);
      while (cyc < n)
         @(negedge clk);
   endtask : at

   // Note = {resync, hard sync, cycle}; a pin change at edge n shows as a pulse at n+3
   task automatic note(input logic [1:0] kind, input int n);
      notes.push_back({kind, n[13:0]});
   endtask : note

   always @(negedge clk)
   begin
      if (hs === 1'b1 || rs === 1'b1)
      begin
         if (notes.size() == 0)
            cmp("sync", 16'h0000, {rs, hs, cyc[13:0]});
         else
            cmp("sync", notes.pop_front(), {rs, hs, cyc[13:0]});
      end
      if (cyc > 2000)
      begin
         bad_count++;
         summarize();
      end
   end

   // ==========================================================
   // Frame: quantum = 1 clock, tseg1 4, ps2 3, jump 2, bit = 8 clocks
   initial
   begin
      void'($urandom(89679));
      rst = 1'b1;
      en = 1'b1;
      idle = 1'b1;
      tx_dom = 1'b0;
      oth_dom = 1'b0;
      cfg = '{brp_m1: 6'h00, tseg1: 5'h04, ps2: 4'h3, sjw_m1: 2'h1};
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      h = cyc + 8 + int'($urandom % 8);
      go(h - 3);
      oth_dom = 1'b1;
      note(2'b01, h);
      go(h);
      cmp("segment", {13'h0000, cbs_pkg::CBS_TS1}, {13'h0000, seg});
      oth_dom = 1'b0;
      go(h + 1);
      idle = 1'b0;
      oth_dom = 1'b1;
      at(h + 4);
      cmp("sample", 16'h0001, {15'h0000, smp});
      cmp("rx_bit", 16'h0000, {15'h0000, rx_bit});
      go(h + 6);
      oth_dom = 1'b0;
      at(h + 12);
      cmp("rx_bit", 16'h0001, {15'h0000, rx_bit});
      k = int'($urandom % 2);
      go(h + 14 + k);
      oth_dom = 1'b1;
      r = h + 17 + k;
      note(2'b10, r);
      go(r);
      oth_dom = 1'b0;
      go(r + 1);
      oth_dom = 1'b1;
      go(r + 5);
      oth_dom = 1'b0;
      go(r + 17);
      oth_dom = 1'b1;
      note(2'b10, r + 20);
      at(r + 20);
      cmp("sample", 16'h0000, {15'h0000, smp});
      at(r + 22);
      cmp("sample", 16'h0001, {15'h0000, smp});
      go(r + 26);
      oth_dom = 1'b0;
      go(r + 28);
      oth_dom = 1'b1;
      note(2'b10, r + 31);
      go(r + 32);
      cmp("segment", {13'h0000, cbs_pkg::CBS_TS1}, {13'h0000, seg});
      oth_dom = 1'b0;
      at(r + 36);
      cmp("sample", 16'h0001, {15'h0000, smp});
      go(r + 40);
      tx_dom = 1'b1;
      at(r + 44);
      cmp("sample", 16'h0001, {15'h0000, smp});
      go(r + 46);
      tx_dom = 1'b0;
      go(r + 50);
      idle = 1'b1;
      at(r + 70);
      cmp("pending", 16'h0000, 16'(notes.size()));
      // Quantum of three clocks: a tick every third cycle
      go(r + 71);
      cfg.brp_m1 = 6'h02;
      for (int i = 0; i < 9; i++)
      begin
         at(r + 72 + i);
         cmp("tq_tick", {15'h0000, (i % 3 == 2)}, {15'h0000, tick});
      end
      // Enable low must freeze the prescaler, so the tick slips by the frozen cycles
      go(r + 81);
      en = 1'b0;
      at(r + 83);
      cmp("tq_tick", 16'h0000, {15'h0000, tick});
      go(r + 86);
      en = 1'b1;
      at(r + 88);
      cmp("tq_tick", 16'h0001, {15'h0000, tick});
      summarize();
   end
endmodule : tb

`default_nettype wire
